/* File: oms_top.sv */
// Operating mode select: strap capture, mode decode, mode indicator and bus/RAM controls.
// Assumes a register master that never issues read and write together, one-cycle strobes,
// and strap pins driven by the board and held steady across reset release.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "oms_defines.svh"

module oms_top (
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_mode_strap_pin_2,
    input  wire logic                  i_mode_strap_pin_1,
    input  wire logic                  i_mode_strap_pin_0,
    input  wire logic [15:0]           i_addr,
    input  wire logic [7:0]            i_wr_data,
    input  wire logic                  i_wr_en,
    input  wire logic                  i_rd_en,
    output logic [7:0]                 o_rd_data,
    output oms_pkg::oms_mode_e         o_mode,
    output logic                       o_mode_valid,
    output oms_pkg::oms_cfg_s          o_cfg
);

    // ****************************************
    // Local state
    // ****************************************
    logic                   byte_area_enable;
    logic                   ram_enable_1;
    logic                   ram_enable_2;
    logic                   hit_mode_ind;
    logic                   hit_bus_ctrl;
    logic                   hit_ram_ctrl;
    logic [7:0]             next_rd_data;
    oms_pkg::oms_cfg_s      next_cfg;

    // ****************************************
    // Mode capture
    // ****************************************
    oms_mode_latch u_mode_latch (
        .i_ref_clk    (i_ref_clk),
        .i_rst_n      (i_rst_n),
        .i_strap      ({i_mode_strap_pin_2, i_mode_strap_pin_1, i_mode_strap_pin_0}),
        .o_mode       (o_mode),
        .o_mode_valid (o_mode_valid)
    );

    // ****************************************
    // Address decode
    // ****************************************
    assign hit_mode_ind = (i_addr == `OMS_MODE_IND_ADDR);
    assign hit_bus_ctrl = (i_addr == `OMS_BUS_CTRL_ADDR);
    assign hit_ram_ctrl = (i_addr == `OMS_RAM_CTRL_ADDR);

    // ****************************************
    // Bus control register
    // ****************************************
    // Stored in every mode; it only steers decode in modes 5 and 6
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            byte_area_enable <= `OMS_BUS_CTRL_RESET;
        end else if (i_wr_en && hit_bus_ctrl) begin
            byte_area_enable <= i_wr_data[`OMS_BYTE_AREA_EN_BIT];
        end
    end

    // ****************************************
    // RAM control register
    // ****************************************
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {ram_enable_2, ram_enable_1} <= `OMS_RAM_CTRL_RESET;
        end else if (i_wr_en && hit_ram_ctrl) begin
            ram_enable_1 <= i_wr_data[`OMS_RAM_EN1_BIT];
            ram_enable_2 <= i_wr_data[`OMS_RAM_EN2_BIT];
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    // Writes to the mode indicator are dropped: the field only changes at reset release
    always_comb begin
        next_rd_data = 8'h00;
        if (hit_mode_ind) begin
            next_rd_data = {`OMS_MODE_IND_HI, `OMS_MODE_IND_MID, o_mode};
        end else if (hit_bus_ctrl) begin
            next_rd_data[`OMS_BYTE_AREA_EN_BIT] = byte_area_enable;
        end else if (hit_ram_ctrl) begin
            next_rd_data[`OMS_RAM_EN1_BIT] = ram_enable_1;
            next_rd_data[`OMS_RAM_EN2_BIT] = ram_enable_2;
        end
    end

    // Data is zero outside the answer cycle so stale values never linger
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rd_data <= 8'h00;
        end else if (i_rd_en) begin
            o_rd_data <= next_rd_data;
        end else begin
            o_rd_data <= 8'h00;
        end
    end

    // ****************************************
    // Mode decode
    // ****************************************
    // Until capture completes everything external stays off
    always_comb begin
        next_cfg                    = '0;
        next_cfg.ram_enable         = 1'b1;
        next_cfg.mode_reserved      = o_mode_valid && (o_mode == oms_pkg::OMS_MODE_RSVD);
        if (o_mode_valid) begin
            unique case (o_mode)
                oms_pkg::OMS_MODE_RSVD: begin
                    next_cfg.all_ports_gpio = 1'b1;
                end
                oms_pkg::OMS_MODE_1, oms_pkg::OMS_MODE_6: begin
                    next_cfg.ext_enable    = 1'b1;
                    next_cfg.ext_addr_bits = `OMS_MIN_ADDR_BITS;
                    next_cfg.data_bus_16   = 1'b1;
                end
                oms_pkg::OMS_MODE_2: begin
                    next_cfg.ext_enable    = 1'b1;
                    next_cfg.ext_addr_bits = `OMS_MIN_ADDR_BITS;
                    next_cfg.data_bus_8    = 1'b1;
                    next_cfg.rom_enable    = 1'b1;
                end
                oms_pkg::OMS_MODE_3, oms_pkg::OMS_MODE_5: begin
                    next_cfg.ext_enable    = 1'b1;
                    next_cfg.ext_addr_bits = `OMS_MAX_ADDR_BITS;
                    next_cfg.data_bus_16   = 1'b1;
                end
                oms_pkg::OMS_MODE_4: begin
                    next_cfg.ext_enable    = 1'b1;
                    next_cfg.ext_addr_bits = `OMS_MAX_ADDR_BITS;
                    next_cfg.data_bus_16   = 1'b1;
                    next_cfg.rom_enable    = 1'b1;
                end
                oms_pkg::OMS_MODE_7: begin
                    next_cfg.all_ports_gpio = 1'b1;
                    next_cfg.rom_enable     = 1'b1;
                end
            endcase
            // Byte area: fixed on in 1,3,4; ignored in 2 and 7; under software control in 5,6
            unique case (o_mode)
                oms_pkg::OMS_MODE_1, oms_pkg::OMS_MODE_3, oms_pkg::OMS_MODE_4: begin
                    next_cfg.byte_area_active = 1'b1;
                end
                oms_pkg::OMS_MODE_5, oms_pkg::OMS_MODE_6: begin
                    next_cfg.byte_area_active   = byte_area_enable;
                    next_cfg.all_space_8bit_3st = !byte_area_enable;
                end
                oms_pkg::OMS_MODE_RSVD, oms_pkg::OMS_MODE_2, oms_pkg::OMS_MODE_7: begin
                    next_cfg.byte_area_active = 1'b0;
                end
            endcase
            // RAM space goes external only where an external bus exists
            next_cfg.ram_external = next_cfg.ext_enable && !ram_enable_1 && !ram_enable_2;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cfg <= '0;
        end else begin
            o_cfg <= next_cfg;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);

    sequence s_mode_read;
        i_rd_en && hit_mode_ind;
    endsequence

    sequence s_byte_area_set;
        i_wr_en && hit_bus_ctrl && i_wr_data[`OMS_BYTE_AREA_EN_BIT];
    endsequence

    sequence s_mode_56;
        o_mode_valid && (o_mode == oms_pkg::OMS_MODE_5 || o_mode == oms_pkg::OMS_MODE_6);
    endsequence

    AST_MODE_READ: assert property (s_mode_read |=> o_rd_data == {5'h18, $past(o_mode)})
        else $error("Mode indicator read value wrong");

    AST_MODE_FIELD: assert property (s_mode_read ##1 o_mode_valid |-> o_rd_data[2:0] == o_mode)
        else $error("Mode field does not match latched mode");

    AST_MIN_SPACE: assert property (o_mode_valid &&
        (o_mode == oms_pkg::OMS_MODE_1 || o_mode == oms_pkg::OMS_MODE_2 || o_mode == oms_pkg::OMS_MODE_6)
        |=> o_cfg.ext_enable && o_cfg.ext_addr_bits == 5'h10)
        else $error("Minimum mode address space wrong");

    AST_MAX_SPACE: assert property (o_mode_valid &&
        (o_mode == oms_pkg::OMS_MODE_3 || o_mode == oms_pkg::OMS_MODE_4 || o_mode == oms_pkg::OMS_MODE_5)
        |=> o_cfg.ext_enable && o_cfg.ext_addr_bits == 5'h14)
        else $error("Maximum mode address space wrong");

    AST_SINGLE_CHIP: assert property (o_mode_valid && o_mode == oms_pkg::OMS_MODE_7
        |=> o_cfg.all_ports_gpio && !o_cfg.ext_enable && !o_cfg.data_bus_8 && !o_cfg.data_bus_16)
        else $error("Single-chip mode exposes external bus");

    AST_ROM: assert property (o_mode_valid |=> o_cfg.rom_enable ==
        ($past(o_mode) == oms_pkg::OMS_MODE_2 || $past(o_mode) == oms_pkg::OMS_MODE_4
         || $past(o_mode) == oms_pkg::OMS_MODE_7))
        else $error("ROM enable does not follow mode");

    AST_BUS_WIDTH: assert property (o_mode_valid |=>
        o_cfg.data_bus_8 == ($past(o_mode) == oms_pkg::OMS_MODE_2) &&
        o_cfg.data_bus_16 == (o_cfg.ext_enable && $past(o_mode) != oms_pkg::OMS_MODE_2))
        else $error("Data bus width does not follow mode");

    AST_BYTE_AREA_FIXED: assert property (o_mode_valid &&
        (o_mode == oms_pkg::OMS_MODE_1 || o_mode == oms_pkg::OMS_MODE_3 || o_mode == oms_pkg::OMS_MODE_4)
        |=> o_cfg.byte_area_active)
        else $error("Byte area inactive in mode 1, 3 or 4");

    AST_BYTE_AREA_MODE2: assert property (o_mode_valid && o_mode == oms_pkg::OMS_MODE_2
        |=> !o_cfg.byte_area_active && !o_cfg.all_space_8bit_3st)
        else $error("Byte area affects mode 2");

    AST_POST_RESET_56: assert property (s_mode_56 ##0 !byte_area_enable
        |=> o_cfg.all_space_8bit_3st && !o_cfg.byte_area_active)
        else $error("Modes 5/6 not in 8-bit three-state setup");

    AST_BYTE_AREA_SET: assert property (s_mode_56 ##0 s_byte_area_set
        |-> ##2 o_cfg.byte_area_active && !o_cfg.all_space_8bit_3st)
        else $error("Byte-area enable write not honoured");

    AST_RAM: assert property (o_mode_valid |=> o_cfg.ram_enable &&
        o_cfg.ram_external == ($past(o_mode) != oms_pkg::OMS_MODE_7 && $past(o_mode) != oms_pkg::OMS_MODE_RSVD
                               && !$past(ram_enable_1) && !$past(ram_enable_2)))
        else $error("RAM mapping does not follow enables");

    AST_MODE_STABLE: assert property (o_mode_valid |-> ##1 $stable(o_mode) ##1 $stable(o_mode))
        else $error("Latched mode moved while out of reset");

    // ****************************************
    // Register port checks
    // ****************************************
    // Idle cycles must read zero so a late sampler cannot see stale data
    AST_RD_IDLE: assert property (!i_rd_en |=> o_rd_data == 8'h00)
        else $error("Read data not zero outside the answer cycle");

    AST_MODE_IND_RO: assert property (i_wr_en && hit_mode_ind && o_mode_valid
        |=> $stable(o_mode))
        else $error("Write to mode indicator moved the mode");

    AST_BUS_CTRL_READ: assert property (i_rd_en && hit_bus_ctrl |=>
        o_rd_data == {7'h00, $past(byte_area_enable)})
        else $error("Bus control read value wrong");

    AST_RAM_CTRL_READ: assert property (i_rd_en && hit_ram_ctrl |=>
        o_rd_data == {6'h00, $past(ram_enable_2), $past(ram_enable_1)})
        else $error("RAM control read value wrong");

    AST_UNMAPPED_READ: assert property (i_rd_en && !hit_mode_ind && !hit_bus_ctrl && !hit_ram_ctrl
        |=> o_rd_data == 8'h00)
        else $error("Unmapped read not zero");

    // Control registers take writes in every mode; only the decode looks at the mode
    AST_BUS_CTRL_WRITE: assert property (i_wr_en && hit_bus_ctrl
        |=> byte_area_enable == $past(i_wr_data[`OMS_BYTE_AREA_EN_BIT]))
        else $error("Byte-area enable write lost");

    AST_RAM_CTRL_WRITE: assert property (i_wr_en && hit_ram_ctrl |=>
        ram_enable_1 == $past(i_wr_data[`OMS_RAM_EN1_BIT]) && ram_enable_2 == $past(i_wr_data[`OMS_RAM_EN2_BIT]))
        else $error("RAM enable write lost");

    // ****************************************
    // Decode checks
    // ****************************************
    // Decode outputs lag the latched mode by one edge, hence the next-cycle form
    // Before capture nothing external may switch on, whatever the straps say
    AST_PRE_CAPTURE: assert property (!o_mode_valid |=>
        !o_cfg.ext_enable && !o_cfg.rom_enable && !o_cfg.byte_area_active && !o_cfg.all_ports_gpio)
        else $error("Configuration active before mode capture");

    AST_RESERVED: assert property (o_mode_valid && o_mode == oms_pkg::OMS_MODE_RSVD
        |=> o_cfg.mode_reserved && !o_cfg.ext_enable && !o_cfg.rom_enable)
        else $error("Reserved mode not held in safe setup");

    AST_RAM_ON: assert property (o_mode_valid |-> o_cfg.ram_enable)
        else $error("On-chip RAM disabled");

    AST_EXT_RAM_NEEDS_BUS: assert property (o_cfg.ram_external |-> o_cfg.ext_enable)
        else $error("RAM mapped outside without an external bus");

    AST_MODE5_AS_3: assert property (o_mode_valid &&
        (o_mode == oms_pkg::OMS_MODE_3 || o_mode == oms_pkg::OMS_MODE_5)
        |=> o_cfg.ext_addr_bits == 5'h14 && o_cfg.data_bus_16 && !o_cfg.rom_enable && !o_cfg.data_bus_8)
        else $error("Mode 5 does not match mode 3");

    AST_MODE6_AS_1: assert property (o_mode_valid &&
        (o_mode == oms_pkg::OMS_MODE_1 || o_mode == oms_pkg::OMS_MODE_6)
        |=> o_cfg.ext_addr_bits == 5'h10 && o_cfg.data_bus_16 && !o_cfg.rom_enable && !o_cfg.data_bus_8)
        else $error("Mode 6 does not match mode 1");

    sequence s_byte_area_clear;
        i_wr_en && hit_bus_ctrl && !i_wr_data[`OMS_BYTE_AREA_EN_BIT];
    endsequence

    AST_BYTE_AREA_CLEAR: assert property (s_mode_56 ##0 s_byte_area_clear
        |-> ##2 !o_cfg.byte_area_active && o_cfg.all_space_8bit_3st)
        else $error("Byte-area disable write not honoured");

    AST_3ST_EXCLUSIVE: assert property (o_cfg.all_space_8bit_3st |-> !o_cfg.byte_area_active)
        else $error("Whole-space 8-bit access with byte area active");

    AST_FIXED_NO_3ST: assert property (o_mode_valid &&
        (o_mode == oms_pkg::OMS_MODE_1 || o_mode == oms_pkg::OMS_MODE_3 || o_mode == oms_pkg::OMS_MODE_4)
        |=> !o_cfg.all_space_8bit_3st)
        else $error("Byte-area modes report whole-space 8-bit access");

    AST_SINGLE_CHIP_RAM: assert property (o_mode_valid && o_mode == oms_pkg::OMS_MODE_7
        |=> !o_cfg.ram_external && o_cfg.ext_addr_bits == 5'h00)
        else $error("Single-chip mode maps RAM or address space outside");

    AST_GPIO_NO_BUS: assert property (o_cfg.all_ports_gpio
        |-> !o_cfg.ext_enable && !o_cfg.data_bus_16 && !o_cfg.data_bus_8)
        else $error("General I/O ports with an external bus");

    AST_BUS_EXCLUSIVE: assert property (!(o_cfg.data_bus_8 && o_cfg.data_bus_16))
        else $error("Both data bus widths reported");

endmodule

/* File: oms_defines.svh */
// Constants for the operating mode select block: offsets, field positions, resets.
// Assumes an 8-bit register port with a 16-bit byte address.
`ifndef OMS_DEFINES_SVH
`define OMS_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define OMS_MODE_IND_ADDR   16'hff19
`define OMS_BUS_CTRL_ADDR   16'hff12
`define OMS_RAM_CTRL_ADDR   16'hff15

// ****************************************
// Field positions
// ****************************************
`define OMS_BYTE_AREA_EN_BIT 0
`define OMS_RAM_EN1_BIT      0
`define OMS_RAM_EN2_BIT      1

// ****************************************
// Reset and fixed values
// ****************************************
`define OMS_BUS_CTRL_RESET  1'b0
`define OMS_RAM_CTRL_RESET  2'h3
`define OMS_MODE_IND_HI     2'h3
`define OMS_MODE_IND_MID    3'h0
`define OMS_MIN_ADDR_BITS   5'h10
`define OMS_MAX_ADDR_BITS   5'h14

`endif

/* File: oms_pkg.sv */
// Types shared by the operating mode select block.
// Assumes oms_defines.svh supplies all numeric constants.
package oms_pkg;

    typedef enum logic [2:0] {
        OMS_MODE_RSVD = 3'h0,
        OMS_MODE_1    = 3'h1,
        OMS_MODE_2    = 3'h2,
        OMS_MODE_3    = 3'h3,
        OMS_MODE_4    = 3'h4,
        OMS_MODE_5    = 3'h5,
        OMS_MODE_6    = 3'h6,
        OMS_MODE_7    = 3'h7
    } oms_mode_e;

    // Gray along settle -> settle -> capture -> held
    typedef enum logic [1:0] {
        OMS_LS_SETTLE0 = 2'h0,
        OMS_LS_SETTLE1 = 2'h1,
        OMS_LS_CAPTURE = 2'h3,
        OMS_LS_HELD    = 2'h2
    } oms_latch_state_e;

    typedef struct packed {
        logic       mode_reserved;
        logic       ext_enable;
        logic [4:0] ext_addr_bits;
        logic       rom_enable;
        logic       data_bus_16;
        logic       data_bus_8;
        logic       byte_area_active;
        logic       all_space_8bit_3st;
        logic       all_ports_gpio;
        logic       ram_enable;
        logic       ram_external;
    } oms_cfg_s;

endpackage

/* File: oms_mode_latch.sv */
// Strap synchroniser and capture of the operating mode after reset release.
// Assumes strap pins are static around reset release; they come from outside the clock domain.
`timescale 1ns/1ps
`include "oms_defines.svh"

module oms_mode_latch (
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_rst_n,
    input  wire logic [2:0]            i_strap,
    output oms_pkg::oms_mode_e         o_mode,
    output logic                       o_mode_valid
);

    logic [2:0]                 strap_meta;
    logic [2:0]                 strap_sync;
    oms_pkg::oms_latch_state_e  state;

    // ****************************************
    // Two-stage synchroniser
    // ****************************************
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            strap_meta <= 3'h0;
            strap_sync <= 3'h0;
        end else begin
            strap_meta <= i_strap;
            strap_sync <= strap_meta;
        end
    end

    // ****************************************
    // Capture sequencer
    // ****************************************
    // Waits two edges so the synchroniser holds real pin levels, not its reset value
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= oms_pkg::OMS_LS_SETTLE0;
        end else begin
            unique case (state)
                oms_pkg::OMS_LS_SETTLE0: state <= oms_pkg::OMS_LS_SETTLE1;
                oms_pkg::OMS_LS_SETTLE1: state <= oms_pkg::OMS_LS_CAPTURE;
                oms_pkg::OMS_LS_CAPTURE: state <= oms_pkg::OMS_LS_HELD;
                oms_pkg::OMS_LS_HELD:    state <= oms_pkg::OMS_LS_HELD;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_mode       <= oms_pkg::OMS_MODE_RSVD;
            o_mode_valid <= 1'b0;
        end else if (state == oms_pkg::OMS_LS_CAPTURE) begin
            o_mode       <= oms_pkg::oms_mode_e'(strap_sync);
            o_mode_valid <= 1'b1;
        end
    end

    AST_CAPTURE: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        state == oms_pkg::OMS_LS_CAPTURE |=> o_mode_valid && (o_mode == $past(strap_sync)))
        else $error("Mode not captured from synchronised straps");

    AST_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_mode_valid |=> o_mode_valid && $stable(o_mode))
        else $error("Latched mode changed outside reset");

endmodule

/* File: oms_board_model.sv */
// Board model for the operating mode select block: drives the three mode straps.
// Assumes the bench names a mode and says when the board may move the straps.
`timescale 1ns/1ps

module oms_board_model (
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    input  wire logic [2:0] i_mode_req,
    input  wire logic       i_late_move,
    output logic            o_mode_strap_pin_2,
    output logic            o_mode_strap_pin_1,
    output logic            o_mode_strap_pin_0,
    output logic            o_flash_write_enable_pin
);
    logic [2:0] safe_mode;

    // ****************************************
    // Strap levels
    // ****************************************
    // Reserved all-low code never reaches the pins
    assign safe_mode = (i_mode_req == 3'h0) ? 3'h7 : i_mode_req;

    // Straps only move under reset, or when the bench asks on purpose
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || i_late_move) begin
            {o_mode_strap_pin_2, o_mode_strap_pin_1, o_mode_strap_pin_0} <= safe_mode;
        end
    end

    // No flash programming from this board, so the enable stays low
    assign o_flash_write_enable_pin = 1'b0;

    // Straps stay unknown until the first edge, which always falls inside reset
endmodule

/* File: oms_tb_top.sv */
// Self-checking bench for the operating mode select block, modes 1 to 7 in turn.
// Assumes oms_defines.svh offsets and the one-cycle read latency of the register port.
`timescale 1ns/1ps
`include "oms_defines.svh"

`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin errors++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end

module oms_tb_top;
    logic              ref_clk;
    logic              rst_n;
    logic [2:0]        mode_req;
    logic              late_move;
    logic              strap_2;
    logic              strap_1;
    logic              strap_0;
    logic [15:0]       addr;
    logic [7:0]        wr_data;
    logic              wr_en;
    logic              rd_en;
    logic [7:0]        rd_data;
    oms_pkg::oms_mode_e mode;
    logic              mode_valid;
    oms_pkg::oms_cfg_s cfg;
    integer            errors;
    integer            num_checks;
    integer            seed;
    logic [7:0]        d;
    logic [7:0]        r;

    oms_board_model i_oms_board_model (
        .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_mode_req(mode_req), .i_late_move(late_move),
        .o_mode_strap_pin_2(strap_2), .o_mode_strap_pin_1(strap_1), .o_mode_strap_pin_0(strap_0),
        .o_flash_write_enable_pin()
    );

    oms_top i_oms_top (
        .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_mode_strap_pin_2(strap_2),
        .i_mode_strap_pin_1(strap_1), .i_mode_strap_pin_0(strap_0), .i_addr(addr),
        .i_wr_data(wr_data), .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rd_data(rd_data),
        .o_mode(mode), .o_mode_valid(mode_valid), .o_cfg(cfg)
    );

    // ****************************************
    // Reference model
    // ****************************************
    function automatic oms_pkg::oms_cfg_s exp_cfg(input int m, input int bae, input int ram);
        oms_pkg::oms_cfg_s c;
        c = '0;
        c.ram_enable         = 1'b1;
        c.ext_enable         = (m != 7);
        c.ext_addr_bits      = (m >= 3 && m <= 5) ? 5'h14 : ((m != 7) ? 5'h10 : 5'h00);
        c.rom_enable         = (m == 2 || m == 4 || m == 7);
        c.data_bus_8         = (m == 2);
        c.data_bus_16        = (m != 7 && m != 2);
        c.byte_area_active   = (m == 1 || m == 3 || m == 4) || ((m == 5 || m == 6) && bae != 0);
        c.all_space_8bit_3st = (m == 5 || m == 6) && bae == 0;
        c.all_ports_gpio     = (m == 7);
        c.ram_external       = (m != 7) && ram == 0;
        return c;
    endfunction

    // ****************************************
    // Register port master
    // ****************************************
    task automatic rd(input logic [15:0] a, output logic [7:0] q);
        @(posedge ref_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 q = rd_data;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        addr    <= a;
        wr_data <= v;
        wr_en   <= 1'b1;
        @(posedge ref_clk);
        wr_en   <= 1'b0;
        // Control register lands one edge later, decode one more
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    task automatic do_reset(input int m);
        @(posedge ref_clk);
        mode_req <= 3'(m);
        rst_n    <= 1'b0;
        repeat (5) @(posedge ref_clk);
        `CHK("mode_valid_in_reset", 1'b0, mode_valid)
        rst_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        #1;
    endtask

    task automatic tally_and_finish;
        if (errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // Clock, watchdog, main sequence
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge ref_clk);
        errors++;
        tally_and_finish;
    end

    initial begin
        errors = 0; num_checks = 0; seed = 48;
        rst_n = 1'b0; mode_req = 3'h1; late_move = 1'b0;
        addr = 16'h0000; wr_data = 8'h00; wr_en = 1'b0; rd_en = 1'b0;
        for (int m = 1; m <= 7; m++) begin
            do_reset(m);
            `CHK("mode_valid", 1'b1, mode_valid)
            `CHK("mode", 3'(m), mode)
            rd(`OMS_MODE_IND_ADDR, d);
            `CHK("mode_ind", {2'b11, 3'b000, 3'(m)}, d)
            @(posedge ref_clk);
            #1;
            `CHK("rd_idle", 8'h00, rd_data)
            `CHK("cfg_reset", exp_cfg(m, 0, 3), cfg)
            wr(`OMS_MODE_IND_ADDR, 8'($random(seed)));
            rd(`OMS_MODE_IND_ADDR, d);
            `CHK("mode_ind_ro", {2'b11, 3'b000, 3'(m)}, d)
            rd(`OMS_BUS_CTRL_ADDR, d);
            `CHK("bus_ctrl_rst", 8'h00, d)
            wr(`OMS_BUS_CTRL_ADDR, 8'h01);
            `CHK("cfg_byte_area", exp_cfg(m, 1, 3), cfg)
            wr(`OMS_BUS_CTRL_ADDR, 8'h00);
            rd(`OMS_RAM_CTRL_ADDR, d);
            `CHK("ram_ctrl_rst", 8'h03, d)
            wr(`OMS_RAM_CTRL_ADDR, 8'h01);
            `CHK("cfg_ram_one", exp_cfg(m, 0, 1), cfg)
            wr(`OMS_RAM_CTRL_ADDR, 8'h00);
            `CHK("cfg_ram_off", exp_cfg(m, 0, 0), cfg)
            // Straps moved while out of reset must be ignored
            r = 8'($random(seed));
            @(posedge ref_clk);
            mode_req  <= (r[2:0] == 3'(m) || r[2:0] == 3'h0) ? 3'(m % 7 + 1) : r[2:0];
            late_move <= 1'b1;
            repeat (6) @(posedge ref_clk);
            late_move <= 1'b0;
            #1;
            `CHK("mode_hold", 3'(m), mode)
            rd(`OMS_MODE_IND_ADDR, d);
            `CHK("mode_ind_hold", {2'b11, 3'b000, 3'(m)}, d)
            rd({8'h00, r}, d);
            `CHK("unmapped", 8'h00, d)
        end
        tally_and_finish;
    end
endmodule
